// file: inc/erttr_consts.svh
// Offsets, field positions, reset values and timing counts of the readout bank
`ifndef ERTTR_CONSTS_SVH
`define ERTTR_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ERTTR_OFS_PWM_B_DUTY_HIGH 8'h0F
`define ERTTR_OFS_EXT_BASE        8'h10
`define ERTTR_OFS_EXT_TOP         8'h1F
`define ERTTR_EXT_BASE_HI_NIB     4'h1

// ----------------------------------------------------------------
// Extended byte offsets
// ----------------------------------------------------------------
`define ERTTR_OFS_CPU1_A_RAW_LOW     8'h10
`define ERTTR_OFS_CPU1_A_RAW_HIGH    8'h11
`define ERTTR_OFS_CPU1_B_RAW_LOW     8'h12
`define ERTTR_OFS_CPU1_B_RAW_HIGH    8'h13
`define ERTTR_OFS_CPU2_A_RAW_LOW     8'h14
`define ERTTR_OFS_CPU2_A_RAW_HIGH    8'h15
`define ERTTR_OFS_CPU2_B_RAW_LOW     8'h16
`define ERTTR_OFS_CPU2_B_RAW_HIGH    8'h17
`define ERTTR_OFS_CPU1_A_SMOOTH_LOW  8'h18
`define ERTTR_OFS_CPU1_A_SMOOTH_HIGH 8'h19
`define ERTTR_OFS_CPU1_B_SMOOTH_LOW  8'h1A
`define ERTTR_OFS_CPU1_B_SMOOTH_HIGH 8'h1B
`define ERTTR_OFS_CPU2_A_SMOOTH_LOW  8'h1C
`define ERTTR_OFS_CPU2_A_SMOOTH_HIGH 8'h1D
`define ERTTR_OFS_CPU2_B_SMOOTH_LOW  8'h1E
`define ERTTR_OFS_CPU2_B_SMOOTH_HIGH 8'h1F

// ----------------------------------------------------------------
// Reset and special values
// ----------------------------------------------------------------
`define ERTTR_RST_BYTE            8'h00
`define ERTTR_FAULT_TEMP          8'h80

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define ERTTR_INT_W               8
`define ERTTR_FRAC_FULL_W         4
`define ERTTR_RAW_FRAC_W          1
`define ERTTR_SMOOTH_FRAC_W       4
`define ERTTR_ZONES               4
`define ERTTR_PAIRS               8

// ----------------------------------------------------------------
// Duty cycle generator
// ----------------------------------------------------------------
`define ERTTR_PWM_FULL            9'h100
`define ERTTR_PWM_STEP_CYC        8'h10

`endif

// file: inc/erttr_pkg.sv
// Types shared by the readout bank modules
`default_nettype none
package erttr_pkg;

  typedef logic [7:0] erttr_byte_t;

  typedef logic [11:0] erttr_sample_t;

  typedef enum logic {
    ERTTR_SRC_AUTO,
    ERTTR_SRC_OVERRIDE
  } erttr_pwm_src_t;

endpackage

`default_nettype wire

// file: inc/erttr_zone_if.sv
// Carrier between the bank and one byte-pair latch
`timescale 1ns/1ps
`default_nettype none

interface erttr_zone_if;
  logic                  sample_valid;
  logic                  fault;
  erttr_pkg::erttr_sample_t sample;
  erttr_pkg::erttr_byte_t   low;
  erttr_pkg::erttr_byte_t   high;

  modport src  (output sample_valid, output fault, output sample, input low, input high);
  modport sink (input sample_valid, input fault, input sample, output low, output high);
endinterface

`default_nettype wire

// file: src/erttr_pwm_out.sv
// Duty cycle generator for the second fan output
`timescale 1ns/1ps
`default_nettype none
`include "erttr_consts.svh"

module erttr_pwm_out (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic [8:0] duty_i,
  output logic            pwm_o
);

  logic [7:0] div_q;
  logic [7:0] div_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [8:0] duty_q;
  logic [8:0] duty_d;
  logic       pwm_q;
  logic       pwm_d;
  logic       step;

  // ----------------------------------------------------------------
  // Step divider, counter and compare
  // ----------------------------------------------------------------
  always_comb begin
    step   = (div_q == 8'(`ERTTR_PWM_STEP_CYC - 8'h01));
    div_d  = step ? 8'h00 : 8'(div_q + 8'h01);
    cnt_d  = step ? 8'(cnt_q + 8'h01) : cnt_q;
    duty_d = duty_q;
    // New duty taken at the start of a period so no runt pulse appears
    if (step && (cnt_q == 8'hFF)) begin
      duty_d = (duty_i > `ERTTR_PWM_FULL) ? `ERTTR_PWM_FULL : duty_i;
    end
    pwm_d = (duty_q > {1'b0, cnt_q});
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      div_q  <= 8'h00;
      cnt_q  <= 8'h00;
      duty_q <= 9'h000;
      pwm_q  <= 1'b0;
    end else begin
      div_q  <= div_d;
      cnt_q  <= cnt_d;
      duty_q <= duty_d;
      pwm_q  <= pwm_d;
    end
  end

  assign pwm_o = pwm_q;

endmodule

`default_nettype wire

// file: src/erttr_top.sv
// Extended-resolution temperature readout bank with second fan override byte
`timescale 1ns/1ps
`default_nettype none
`include "erttr_consts.svh"

module erttr_top (
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  output logic                   reg_rvalid_o,
  input  wire logic [3:0]        raw_valid_i,
  input  wire logic [3:0][8:0]   raw_temp_i,
  input  wire logic [3:0]        smooth_valid_i,
  input  wire logic [3:0][11:0]  smooth_temp_i,
  input  wire logic [3:0]        diode_fault_i,
  input  wire logic              pwm_b_fine_override_enable_i,
  input  wire logic              pwm_b_override_duty_lsb_i,
  input  wire logic [7:0]        pwm_b_auto_duty_i,
  output logic      [7:0]        pwm_b_override_duty_upper_o,
  output logic      [7:0][7:0]   zone_temp_high_o,
  output logic                   fan_pwm_output_b_o
);

  // ----------------------------------------------------------------
  // Byte-pair latches
  // ----------------------------------------------------------------
  erttr_zone_if pair_if [`ERTTR_PAIRS] ();

  erttr_pkg::erttr_byte_t pair_low  [`ERTTR_PAIRS];
  erttr_pkg::erttr_byte_t pair_high [`ERTTR_PAIRS];

  for (genvar z = 0; z < `ERTTR_ZONES; z++) begin : g_zone
    // Raw pair: 8 integer bits and one half-degree bit
    assign pair_if[z].sample_valid = raw_valid_i[z];
    assign pair_if[z].fault        = diode_fault_i[z];
    assign pair_if[z].sample       = {raw_temp_i[z], 3'b000};
    // Smoothed pair comes from the spike filter engine outside
    assign pair_if[z+4].sample_valid = smooth_valid_i[z];
    assign pair_if[z+4].fault        = diode_fault_i[z];
    assign pair_if[z+4].sample       = smooth_temp_i[z];

    erttr_zone_latch #(.FRAC_W(`ERTTR_RAW_FRAC_W)) u_raw (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .zone       (pair_if[z])
    );

    erttr_zone_latch #(.FRAC_W(`ERTTR_SMOOTH_FRAC_W)) u_smooth (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .zone       (pair_if[z+4])
    );
  end

  for (genvar p = 0; p < `ERTTR_PAIRS; p++) begin : g_pair
    assign pair_low[p]  = pair_if[p].low;
    assign pair_high[p] = pair_if[p].high;
    // 8-bit zone registers elsewhere read these same flops
    assign zone_temp_high_o[p] = pair_if[p].high;
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic       ovr_hit;
  logic       in_ext;
  logic [2:0] rd_pair;
  logic       rd_is_high;

  // One item per mapped byte; anything else reads as unmapped
  always_comb begin
    ovr_hit    = 1'b0;
    in_ext     = 1'b0;
    rd_pair    = 3'h0;
    rd_is_high = 1'b0;
    case (reg_addr_i)
      `ERTTR_OFS_PWM_B_DUTY_HIGH: begin
        ovr_hit    = 1'b1;
      end
      // Raw pairs
      `ERTTR_OFS_CPU1_A_RAW_LOW: begin
        in_ext     = 1'b1;
        rd_pair    = 3'h0;
        rd_is_high = 1'b0;
      end
      `ERTTR_OFS_CPU1_A_RAW_HIGH: begin
        in_ext     = 1'b1;
        rd_pair    = 3'h0;
        rd_is_high = 1'b1;
      end
      `ERTTR_OFS_CPU1_B_RAW_LOW: begin
        in_ext     = 1'b1;
        rd_pair    = 3'h1;
        rd_is_high = 1'b0;
      end
      `ERTTR_OFS_CPU1_B_RAW_HIGH: begin
        in_ext     = 1'b1;
        rd_pair    = 3'h1;
        rd_is_high = 1'b1;
      end
      `ERTTR_OFS_CPU2_A_RAW_LOW: begin
        in_ext     = 1'b1;
        rd_pair    = 3'h2;
        rd_is_high = 1'b0;
      end
      `ERTTR_OFS_CPU2_A_RAW_HIGH: begin
        in_ext     = 1'b1;
        rd_pair    = 3'h2;
        rd_is_high = 1'b1;
      end
      `ERTTR_OFS_CPU2_B_RAW_LOW: begin
        in_ext     = 1'b1;
        rd_pair    = 3'h3;
        rd_is_high = 1'b0;
      end
      `ERTTR_OFS_CPU2_B_RAW_HIGH: begin
        in_ext     = 1'b1;
        rd_pair    = 3'h3;
        rd_is_high = 1'b1;
      end

      // Smoothed pairs
      `ERTTR_OFS_CPU1_A_SMOOTH_LOW: begin
        in_ext     = 1'b1;
        rd_pair    = 3'h4;
        rd_is_high = 1'b0;
      end
      `ERTTR_OFS_CPU1_A_SMOOTH_HIGH: begin
        in_ext     = 1'b1;
        rd_pair    = 3'h4;
        rd_is_high = 1'b1;
      end
      `ERTTR_OFS_CPU1_B_SMOOTH_LOW: begin
        in_ext     = 1'b1;
        rd_pair    = 3'h5;
        rd_is_high = 1'b0;
      end
      `ERTTR_OFS_CPU1_B_SMOOTH_HIGH: begin
        in_ext     = 1'b1;
        rd_pair    = 3'h5;
        rd_is_high = 1'b1;
      end
      `ERTTR_OFS_CPU2_A_SMOOTH_LOW: begin
        in_ext     = 1'b1;
        rd_pair    = 3'h6;
        rd_is_high = 1'b0;
      end
      `ERTTR_OFS_CPU2_A_SMOOTH_HIGH: begin
        in_ext     = 1'b1;
        rd_pair    = 3'h6;
        rd_is_high = 1'b1;
      end
      `ERTTR_OFS_CPU2_B_SMOOTH_LOW: begin
        in_ext     = 1'b1;
        rd_pair    = 3'h7;
        rd_is_high = 1'b0;
      end
      `ERTTR_OFS_CPU2_B_SMOOTH_HIGH: begin
        in_ext     = 1'b1;
        rd_pair    = 3'h7;
        rd_is_high = 1'b1;
      end
      default: begin
        ovr_hit    = 1'b0;
        in_ext     = 1'b0;
        rd_pair    = 3'h0;
        rd_is_high = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Override high byte
  // ----------------------------------------------------------------
  erttr_pkg::erttr_byte_t duty_upper_q;
  erttr_pkg::erttr_byte_t duty_upper_d;

  always_comb begin
    duty_upper_d = duty_upper_q;
    if (reg_wr_i && ovr_hit) begin
      duty_upper_d = reg_wdata_i;
    end
    // Writes to 10h-1Fh fall through here untouched
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      duty_upper_q <= `ERTTR_RST_BYTE;
    end else begin
      duty_upper_q <= duty_upper_d;
    end
  end

  assign pwm_b_override_duty_upper_o = duty_upper_q;

  // ----------------------------------------------------------------
  // Read path with low-then-high snapshot
  // ----------------------------------------------------------------
  erttr_pkg::erttr_byte_t rdata_q;
  erttr_pkg::erttr_byte_t rdata_d;
  logic                   rvalid_q;
  logic                   rvalid_d;
  erttr_pkg::erttr_byte_t snap_q;
  erttr_pkg::erttr_byte_t snap_d;
  logic [2:0]             snap_pair_q;
  logic [2:0]             snap_pair_d;
  logic                   snap_vld_q;
  logic                   snap_vld_d;

  always_comb begin
    rdata_d     = rdata_q;
    rvalid_d    = reg_rd_i;
    snap_d      = snap_q;
    snap_pair_d = snap_pair_q;
    snap_vld_d  = snap_vld_q;
    if (reg_rd_i) begin
      snap_vld_d = 1'b0;
      if (ovr_hit) begin
        rdata_d = duty_upper_q;
      end else if (in_ext && !rd_is_high) begin
        rdata_d     = pair_low[rd_pair];
        snap_d      = pair_high[rd_pair];
        snap_pair_d = rd_pair;
        snap_vld_d  = 1'b1;
      end else if (in_ext) begin
        if (snap_vld_q && (snap_pair_q == rd_pair)) begin
          rdata_d = snap_q;
        end else begin
          rdata_d = pair_high[rd_pair];
        end
      end else begin
        rdata_d = `ERTTR_RST_BYTE;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_q     <= `ERTTR_RST_BYTE;
      rvalid_q    <= 1'b0;
      snap_q      <= `ERTTR_RST_BYTE;
      snap_pair_q <= 3'h0;
      snap_vld_q  <= 1'b0;
    end else begin
      rdata_q     <= rdata_d;
      rvalid_q    <= rvalid_d;
      snap_q      <= snap_d;
      snap_pair_q <= snap_pair_d;
      snap_vld_q  <= snap_vld_d;
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign reg_rvalid_o = rvalid_q;

  // ----------------------------------------------------------------
  // Second fan output
  // ----------------------------------------------------------------
  erttr_pkg::erttr_pwm_src_t pwm_src;
  logic [8:0]                pwm_duty;

  always_comb begin
    pwm_src  = pwm_b_fine_override_enable_i ? erttr_pkg::ERTTR_SRC_OVERRIDE : erttr_pkg::ERTTR_SRC_AUTO;
    case (pwm_src)
      erttr_pkg::ERTTR_SRC_OVERRIDE: pwm_duty = {duty_upper_q, pwm_b_override_duty_lsb_i};
      erttr_pkg::ERTTR_SRC_AUTO:     pwm_duty = {pwm_b_auto_duty_i, 1'b0};
      default:                       pwm_duty = 9'h000;
    endcase
  end

  erttr_pwm_out u_pwm (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .duty_i     (pwm_duty),
    .pwm_o      (fan_pwm_output_b_o)
  );

endmodule

`default_nettype wire

// file: src/erttr_zone_latch.sv
// One extended-resolution byte pair, loaded from a zone sample
`timescale 1ns/1ps
`default_nettype none
`include "erttr_consts.svh"

module erttr_zone_latch #(
  parameter int FRAC_W = 1
) (
  input  wire logic     core_clk_i,
  input  wire logic     rst_i,
  erttr_zone_if.sink    zone
);

  localparam logic [3:0] FRAC_MASK = 4'(4'hF << (`ERTTR_FRAC_FULL_W - FRAC_W));

  erttr_pkg::erttr_byte_t low_q;
  erttr_pkg::erttr_byte_t low_d;
  erttr_pkg::erttr_byte_t high_q;
  erttr_pkg::erttr_byte_t high_d;

  // ----------------------------------------------------------------
  // Pair update
  // ----------------------------------------------------------------
  always_comb begin
    low_d  = low_q;
    high_d = high_q;
    if (zone.sample_valid) begin
      if (zone.fault) begin
        high_d = `ERTTR_FAULT_TEMP;
        low_d  = `ERTTR_RST_BYTE;
      end else begin
        high_d = zone.sample[11:4];
        low_d  = {zone.sample[3:0] & FRAC_MASK, 4'h0};
      end
    end
  end

  // Both bytes load in one edge
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      low_q  <= `ERTTR_RST_BYTE;
      high_q <= `ERTTR_RST_BYTE;
    end else begin
      low_q  <= low_d;
      high_q <= high_d;
    end
  end

  assign zone.low  = low_q;
  assign zone.high = high_q;

endmodule

`default_nettype wire

// file: tb/erttr_assertions.sv
// Port checker for the readout bank
`timescale 1ns/1ps
`default_nettype none
module erttr_chk (
  input wire logic              core_clk_i,
  input wire logic              rst_i,
  input wire logic [7:0]        reg_addr_i,
  input wire logic [7:0]        reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic              reg_rvalid_o,
  input wire logic [3:0]        raw_valid_i,
  input wire logic [3:0][8:0]   raw_temp_i,
  input wire logic [3:0]        smooth_valid_i,
  input wire logic [3:0][11:0]  smooth_temp_i,
  input wire logic [3:0]        diode_fault_i,
  input wire logic              pwm_b_fine_override_enable_i,
  input wire logic [7:0]        pwm_b_override_duty_upper_o,
  input wire logic [7:0][7:0]   zone_temp_high_o,
  input wire logic              fan_pwm_output_b_o
);
  logic [12:0] full_q;
  logic [12:0] full_d;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_ovr_wr;
    reg_wr_i && reg_addr_i == 8'h0f;
  endsequence
  // Cycles spent at full override duty
  always_comb full_d = (pwm_b_fine_override_enable_i && pwm_b_override_duty_upper_o == 8'h80) ?
                       full_q + {12'h000, ~&full_q} : 13'h0000;
  always_ff @(posedge core_clk_i) full_q <= full_d;
  a_reset_clears: assert property (disable iff (1'b0) rst_i |=> pwm_b_override_duty_upper_o == 8'h00 && zone_temp_high_o == '0)
    else $error("reset value wrong");
  a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read without answer");
  a_no_stray: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("answer without read");
  a_ovr_write: assert property (s_ovr_wr |=> pwm_b_override_duty_upper_o == $past(reg_wdata_i))
    else $error("override byte not written");
  a_full_duty: assert property (full_q > 13'h1100 |-> fan_pwm_output_b_o)
    else $error("full duty output low");
  for (genvar k = 0; k < 4; k++) begin : g_zone
    a_raw_mirror: assert property (raw_valid_i[k] && !diode_fault_i[k] |=> zone_temp_high_o[k] == $past(raw_temp_i[k][8:1]))
      else $error("raw high byte wrong");
    a_smooth_mirror: assert property (smooth_valid_i[k] && !diode_fault_i[k] |=> zone_temp_high_o[k+4] == $past(smooth_temp_i[k][11:4]))
      else $error("smoothed high byte wrong");
    a_fault_value: assert property (raw_valid_i[k] && diode_fault_i[k] |=> zone_temp_high_o[k] == 8'h80)
      else $error("fault value wrong");
    a_high_hold: assert property (!raw_valid_i[k] |=> $stable(zone_temp_high_o[k]))
      else $error("high byte moved");
  end
endmodule
bind erttr_top erttr_chk erttr_chk_inst (
  .core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rvalid_o, .raw_valid_i,
  .raw_temp_i, .smooth_valid_i, .smooth_temp_i, .diode_fault_i, .pwm_b_fine_override_enable_i,
  .pwm_b_override_duty_upper_o, .zone_temp_high_o, .fan_pwm_output_b_o
);
`default_nettype wire

// file: tb/erttr_host.sv
// Host model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module erttr_host (
  input  wire logic       core_clk_i,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // One strobe per access; released lines show the inverse value
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_wr_o <= wr;
    reg_rd_o <= !wr;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge core_clk_i);
    reg_wr_o <= 1'b0;
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
endmodule
`default_nettype wire

// file: tb/tb_ext_res_temp_readout_regs.sv
// Testbench of the readout bank
`timescale 1ns/1ps
`default_nettype none
module tb_ext_res_temp_readout_regs;
  logic             core_clk_i, reg_wr_i, reg_rd_i, reg_rvalid_o, fan_pwm_output_b_o;
  logic             rst_i = 1'b1;
  logic [7:0]       reg_addr_i, reg_wdata_i, reg_rdata_o, pwm_b_override_duty_upper_o;
  logic [7:0]       pwm_b_auto_duty_i = 8'h00;
  logic [3:0]       raw_valid_i = 4'h0, smooth_valid_i = 4'h0, diode_fault_i = 4'h0;
  logic [3:0][8:0]  raw_temp_i = '0;
  logic [3:0][11:0] smooth_temp_i = '0;
  logic [7:0][7:0]  zone_temp_high_o;
  logic             pwm_b_fine_override_enable_i = 1'b0, pwm_b_override_duty_lsb_i = 1'b0;
  logic [7:0]       exp_q[$];
  logic [15:0]      n, e;
  logic [11:0]      t;
  logic [8:0]       duty [3] = '{9'h000, 9'h0c1, 9'h101};
  int               num_errors, total_checks, cyc;
  int               seed = 32'h1191_895d;
  erttr_top erttr_top_inst (.core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .reg_rvalid_o, .raw_valid_i, .raw_temp_i, .smooth_valid_i, .smooth_temp_i, .diode_fault_i,
    .pwm_b_fine_override_enable_i, .pwm_b_override_duty_lsb_i, .pwm_b_auto_duty_i,
    .pwm_b_override_duty_upper_o, .zone_temp_high_o, .fan_pwm_output_b_o);
  erttr_host erttr_host_inst (.core_clk_i, .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    total_checks++;
    if (got !== ex) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    exp_q.push_back(ex);
    erttr_host_inst.access(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    erttr_host_inst.access(1'b1, a, d);
  endtask
  task sample(input logic [1:0] k, input logic [11:0] v);
    @(posedge core_clk_i);
    raw_temp_i[k] <= v[8:0];
    smooth_temp_i[k] <= v;
    raw_valid_i[k] <= 1'b1;
    smooth_valid_i[k] <= 1'b1;
    @(posedge core_clk_i);
    raw_valid_i <= 4'h0;
    smooth_valid_i <= 4'h0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Read monitor and cycle limit
  // ----------------------------------------------------------------
  always @(posedge core_clk_i) begin
    cyc++;
    if (reg_rvalid_o === 1'b1) begin
      chk("rdata", {8'h00, exp_q.pop_front()}, {8'h00, reg_rdata_o});
    end
    if (cyc == 70000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    pwm_b_auto_duty_i <= 8'($random(seed));
    for (int a = 15; a < 32; a++) rd(8'(a), 8'h00);
    for (int a = 16; a < 33; a++) wr(8'(a), 8'($random(seed)));
    for (int a = 16; a < 33; a++) rd(8'(a), 8'h00);
    e = 16'($random(seed));
    wr(8'h0f, e[7:0]);
    rd(8'h0f, e[7:0]);
    chk("upper", {8'h00, e[7:0]}, {8'h00, pwm_b_override_duty_upper_o});
    for (int k = 0; k < 4; k++) begin
      t = 12'($random(seed));
      sample(2'(k), t);
      rd(8'(16 + 2 * k), {t[0], 7'h00});
      rd(8'(17 + 2 * k), t[8:1]);
      rd(8'(24 + 2 * k), {t[3:0], 4'h0});
      rd(8'(25 + 2 * k), t[11:4]);
      chk("high", {8'h00, t[8:1]}, {8'h00, zone_temp_high_o[k]});
      chk("high_f", {8'h00, t[11:4]}, {8'h00, zone_temp_high_o[k+4]});
    end
    diode_fault_i <= 4'h8;
    sample(2'h3, t);
    diode_fault_i <= 4'h0;
    rd(8'h16, 8'h00);
    rd(8'h17, 8'h80);
    sample(2'h0, t);
    rd(8'h10, {t[0], 7'h00});
    sample(2'h0, ~t);
    rd(8'h11, t[8:1]);
    rd(8'h11, ~t[8:1]);
    repeat (8192) @(posedge core_clk_i);
    n = 16'h0000;
    repeat (4096) @(posedge core_clk_i) n += {15'h0000, fan_pwm_output_b_o === 1'b1};
    chk("pwm_auto", {3'h0, pwm_b_auto_duty_i, 5'h00}, n);
    pwm_b_fine_override_enable_i <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      pwm_b_override_duty_lsb_i <= duty[i][0];
      wr(8'h0f, duty[i][8:1]);
      repeat (8192) @(posedge core_clk_i);
      n = 16'h0000;
      repeat (4096) @(posedge core_clk_i) n += {15'h0000, fan_pwm_output_b_o === 1'b1};
      e = (duty[i] > 9'h100) ? 16'h1000 : {3'h0, duty[i], 4'h0};
      chk("pwm_high", e, n);
    end
    chk("pending", 16'h0000, 16'(exp_q.size()));
    tally_and_finish();
  end
endmodule
`default_nettype wire
